// ===== include/dpgc_pkg.sv
// Purpose: Shared types and constants for the digital port group block
// Assumes: One core clock, asynchronous active-low reset
// Notes:   Pins are flattened into one vector, indexed by the pin table
package dpgc_pkg;

   localparam int NPIN = 18;

   typedef enum logic [3:0] {
      DPGC_G2, DPGC_G3, DPGC_G4, DPGC_G5, DPGC_G6, DPGC_G7,
      DPGC_G12, DPGC_G13, DPGC_G14
   } dpgc_grp_e;

   typedef enum logic [2:0] {
      DPGC_K_DIR, DPGC_K_DATA, DPGC_K_PULLUP, DPGC_K_OD,
      DPGC_K_PMC, DPGC_K_CONV
   } dpgc_kind_e;

   typedef struct packed {
      dpgc_kind_e kind;
      dpgc_grp_e  grp;
      logic [7:0] data;
   } dpgc_wr_s;

   typedef struct packed {
      dpgc_kind_e kind;
      dpgc_grp_e  grp;
   } dpgc_rd_s;

   // Group and bit position behind each pin index
   localparam dpgc_grp_e PIN_GRP [NPIN] = '{
      DPGC_G2, DPGC_G2, DPGC_G2, DPGC_G2, DPGC_G3, DPGC_G3, DPGC_G4,
      DPGC_G5, DPGC_G5, DPGC_G6, DPGC_G6, DPGC_G6, DPGC_G7,
      DPGC_G12, DPGC_G12, DPGC_G12, DPGC_G13, DPGC_G14};
   localparam logic [2:0] PIN_BIT [NPIN] = '{
      3'h0, 3'h1, 3'h2, 3'h3, 3'h0, 3'h1, 3'h0, 3'h0, 3'h1,
      3'h0, 3'h1, 3'h2, 3'h0, 3'h0, 3'h1, 3'h2, 3'h7, 3'h7};

   // Pin capability masks, bit i for pin index i
   localparam logic [NPIN-1:0] HAS_OUT_MASK  = 18'h23fff;
   localparam logic [NPIN-1:0] HAS_PU_MASK   = 18'h231f0;
   localparam logic [NPIN-1:0] FORCE_OD_MASK = 18'h00e00;

   // Pin indices with special roles, and the count of converter pins
   localparam int IDX_G5_OD   = 7;
   localparam int IDX_G12_ANA = 13;
   localparam int IDX_G14_ANA = 17;
   localparam int N_CONV_PIN  = 4;

   // Values after reset, converter count limit, unmounted direction read value
   localparam logic [NPIN-1:0] DIR_RST    = 18'h3ffff;
   localparam logic [NPIN-1:0] LATCH_RST  = 18'h00000;
   localparam logic [NPIN-1:0] PULLUP_RST = 18'h00000;
   localparam logic [2:0]      CONV_RST   = 3'h4;
   localparam logic [2:0]      CONV_MAX   = 3'h4;
   localparam logic            OD5_RST    = 1'b0;
   localparam logic            PMC_RST    = 1'b1;
   localparam logic [7:0]      UNMOUNT_DIR = 8'hff;

endpackage : dpgc_pkg

// ===== verilog/dpgc_pin_cell.sv
// Purpose: One port pin: input synchroniser, drive control, read mux
// Assumes: Pad input is asynchronous to clock_i
// Notes:   Output enable is active low
`timescale 1ns/10ps
module dpgc_pin_cell #(
   parameter bit HAS_OUT  = 1'b1,
   parameter bit HAS_PU   = 1'b1,
   parameter bit FORCE_OD = 1'b0
) (
   input  wire logic clock_i,
   input  wire logic rst_b_i,
   input  wire logic pad_i,
   input  wire logic dir_i,
   input  wire logic latch_i,
   input  wire logic pu_i,
   input  wire logic od_i,
   input  wire logic analog_i,
   output logic      pad_o,
   output logic      pad_oe_b_o,
   output logic      pu_en_o,
   output logic      rd_bit_o
);

   logic sync1_q;
   logic sync2_q;
   logic sync3_q;
   logic level_q;
   logic od_eff;

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         sync3_q <= 1'b0;
      end else begin
         sync1_q <= pad_i;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
      end
   end

   // Level accepted once the two later stages agree
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         level_q <= 1'b0;
      end else if (sync2_q == sync3_q) begin
         level_q <= sync3_q;
      end
   end

   assign od_eff     = FORCE_OD | od_i;
   // Open drain only pulls low or releases
   assign pad_o      = od_eff ? 1'b0 : latch_i;
   assign pad_oe_b_o = !(HAS_OUT && !dir_i && !analog_i && !(od_eff && latch_i));
   assign pu_en_o    = HAS_PU && pu_i && dir_i && !analog_i;
   assign rd_bit_o   = analog_i ? 1'b0 : (dir_i ? level_q : latch_i);

endmodule : dpgc_pin_cell

// ===== verilog/dpgc_port_group.sv
// Purpose: Digital port groups 2-7 and 12-14 with direction, latch, pull-up
// Assumes: Register access through plain write and read select ports
// Notes:   Read data appears one cycle after the read select
//
// Overview of operation
// - Port-2 pins set input or output per bit
// - Analog input converted only when channel selects it
// - Reset puts all port-2 pins analog input
// - Port-3 pull-up per bit while input
// - Reset sets port-3 pins to input
// - Port-4 pull-up while input
// - Port-5 pull-ups; first pin optional open drain
// - Port-6 pins open drain only, never high
// - Reset sets ports 4 to 7 input
// - Port-7 pull-up per bit while input
// - Port-12 first pin pull-up while input
// - Port-12 second, third pins input only
// - Port-12 first pin digital or analog select
// - Reset: port-12 first pin analog, others input
// - Port-13 bit 7 fixed input only
// - Port-14 bit 7 analog select, analog at reset
// - Direction 0 drives, 1 input; reset all ones
// - Read gives pin or latch; analog reads zero
`timescale 1ns/10ps
module dpgc_port_group
   import dpgc_pkg::*;
(
   input  wire logic               clock_i,
   input  wire logic               rst_b_i,
   input  wire logic               wr_en_i,
   input  wire dpgc_wr_s           wr_i,
   input  wire dpgc_rd_s           rd_sel_i,
   output logic      [7:0]         rd_data_o,
   input  wire logic [4:0]         converter_channel_select_i,
   output logic      [N_CONV_PIN-1:0] conv_pick_o,
   output logic      [NPIN-1:0]    analog_mode_o,
   output logic                    prohibited_o,
   input  wire logic [NPIN-1:0]    pad_i,
   output logic      [NPIN-1:0]    pad_o,
   output logic      [NPIN-1:0]    pad_oe_b_o,
   output logic      [NPIN-1:0]    pullup_en_o
);

   logic [NPIN-1:0] dir_q;
   logic [NPIN-1:0] latch_q;
   logic [NPIN-1:0] pu_q;
   logic [NPIN-1:0] analog;
   logic [NPIN-1:0] rd_bit;
   logic [2:0]      conv_cfg_q;
   logic            od5_q;
   logic            group12_analog_digital_select_q;
   logic            group14_analog_digital_select_q;
   logic [7:0]      rd_data_d;
   logic [7:0]      rd_data_q;

   // Direction: only pins with an output stage are writable
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         dir_q <= DIR_RST;
      end else if (wr_en_i && wr_i.kind == DPGC_K_DIR) begin
         for (int i = 0; i < NPIN; i++) begin
            if (HAS_OUT_MASK[i] && wr_i.grp == PIN_GRP[i]) begin
               dir_q[i] <= wr_i.data[PIN_BIT[i]];
            end
         end
      end
   end

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         latch_q <= LATCH_RST;
      end else if (wr_en_i && wr_i.kind == DPGC_K_DATA) begin
         for (int i = 0; i < NPIN; i++) begin
            if (HAS_OUT_MASK[i] && wr_i.grp == PIN_GRP[i]) begin
               latch_q[i] <= wr_i.data[PIN_BIT[i]];
            end
         end
      end
   end

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pu_q <= PULLUP_RST;
      end else if (wr_en_i && wr_i.kind == DPGC_K_PULLUP) begin
         for (int i = 0; i < NPIN; i++) begin
            if (HAS_PU_MASK[i] && wr_i.grp == PIN_GRP[i]) begin
               pu_q[i] <= wr_i.data[PIN_BIT[i]];
            end
         end
      end
   end

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         od5_q <= OD5_RST;
      end else if (wr_en_i && wr_i.kind == DPGC_K_OD && wr_i.grp == DPGC_G5) begin
         od5_q <= wr_i.data[0];
      end
   end

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         group12_analog_digital_select_q <= PMC_RST;
         group14_analog_digital_select_q <= PMC_RST;
      end else if (wr_en_i && wr_i.kind == DPGC_K_PMC) begin
         if (wr_i.grp == DPGC_G12) begin
            group12_analog_digital_select_q <= wr_i.data[0];
         end else if (wr_i.grp == DPGC_G14) begin
            group14_analog_digital_select_q <= wr_i.data[7];
         end
      end
   end

   // Count of analog pins, allocated from the lowest port-2 pin up
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         conv_cfg_q <= CONV_RST;
      end else if (wr_en_i && wr_i.kind == DPGC_K_CONV) begin
         conv_cfg_q <= (wr_i.data[2:0] > CONV_MAX) ? CONV_MAX : wr_i.data[2:0];
      end
   end

   always_comb begin
      analog = '0;
      for (int i = 0; i < N_CONV_PIN; i++) begin
         analog[i] = (3'(i) < conv_cfg_q);
      end
      analog[IDX_G12_ANA] = group12_analog_digital_select_q;
      analog[IDX_G14_ANA] = group14_analog_digital_select_q;
   end

   assign analog_mode_o = analog;

   // Converter sees a pin only in analog input mode and when selected
   always_comb begin
      for (int i = 0; i < N_CONV_PIN; i++) begin
         conv_pick_o[i] = analog[i] && dir_q[i] &&
                          (converter_channel_select_i == 5'(i));
      end
   end

   assign prohibited_o = |(analog & ~dir_q);

   genvar g;
   generate
      for (g = 0; g < NPIN; g++) begin : g_pin
         dpgc_pin_cell #(
            .HAS_OUT  (HAS_OUT_MASK[g]),
            .HAS_PU   (HAS_PU_MASK[g]),
            .FORCE_OD (FORCE_OD_MASK[g])
         ) u_cell (
            .clock_i    (clock_i),
            .rst_b_i    (rst_b_i),
            .pad_i      (pad_i[g]),
            .dir_i      (dir_q[g]),
            .latch_i    (latch_q[g]),
            .pu_i       (pu_q[g]),
            .od_i       ((g == IDX_G5_OD) ? od5_q : 1'b0),
            .analog_i   (analog[g]),
            .pad_o      (pad_o[g]),
            .pad_oe_b_o (pad_oe_b_o[g]),
            .pu_en_o    (pullup_en_o[g]),
            .rd_bit_o   (rd_bit[g])
         );
      end
   endgenerate

   // Read mux: unmounted direction bits read one, others zero
   always_comb begin
      rd_data_d = 8'h00;
      if (rd_sel_i.kind == DPGC_K_DIR) begin
         rd_data_d = UNMOUNT_DIR;
         for (int i = 0; i < NPIN; i++) begin
            if (HAS_OUT_MASK[i] && rd_sel_i.grp == PIN_GRP[i]) begin
               rd_data_d[PIN_BIT[i]] = dir_q[i];
            end
         end
      end else if (rd_sel_i.kind == DPGC_K_DATA) begin
         for (int i = 0; i < NPIN; i++) begin
            if (rd_sel_i.grp == PIN_GRP[i]) begin
               rd_data_d[PIN_BIT[i]] = rd_bit[i];
            end
         end
      end else if (rd_sel_i.kind == DPGC_K_PULLUP) begin
         for (int i = 0; i < NPIN; i++) begin
            if (HAS_PU_MASK[i] && rd_sel_i.grp == PIN_GRP[i]) begin
               rd_data_d[PIN_BIT[i]] = pu_q[i];
            end
         end
      end else if (rd_sel_i.kind == DPGC_K_OD) begin
         if (rd_sel_i.grp == DPGC_G5) begin
            rd_data_d[0] = od5_q;
         end
      end else if (rd_sel_i.kind == DPGC_K_PMC) begin
         if (rd_sel_i.grp == DPGC_G12) begin
            rd_data_d[0] = group12_analog_digital_select_q;
         end else if (rd_sel_i.grp == DPGC_G14) begin
            rd_data_d[7] = group14_analog_digital_select_q;
         end
      end else if (rd_sel_i.kind == DPGC_K_CONV) begin
         rd_data_d[2:0] = conv_cfg_q;
      end
   end

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rd_data_q <= 8'h00;
      end else begin
         rd_data_q <= rd_data_d;
      end
   end

   assign rd_data_o = rd_data_q;

   // Checks
   property p_reset_state;
      @(posedge clock_i) $rose(rst_b_i) |->
         (dir_q == DIR_RST && conv_cfg_q == CONV_RST && group12_analog_digital_select_q && group14_analog_digital_select_q);
   endproperty
   a_reset_state: assert property (p_reset_state)
      else $error("State after reset is wrong");

   property p_dir_write;
      @(posedge clock_i) disable iff (!rst_b_i)
         (wr_en_i && wr_i.kind == DPGC_K_DIR && wr_i.grp == DPGC_G2) |=>
         (dir_q[3:0] == $past(wr_i.data[3:0]));
   endproperty
   a_dir_write: assert property (p_dir_write)
      else $error("Port-2 direction write not taken");

   property p_input_only;
      @(posedge clock_i) disable iff (!rst_b_i)
         pad_oe_b_o[16:14] == 3'h7 && dir_q[16:14] == 3'h7;
   endproperty
   a_input_only: assert property (p_input_only)
      else $error("Input-only pin is driven");

   property p_od_never_high;
      @(posedge clock_i) disable iff (!rst_b_i)
         (pad_o[11:9] == 3'h0) && ((~pad_oe_b_o[11:9] & latch_q[11:9]) == 3'h0);
   endproperty
   a_od_never_high: assert property (p_od_never_high)
      else $error("Open-drain pin drives high");

   property p_od5;
      @(posedge clock_i) disable iff (!rst_b_i)
         (od5_q && !dir_q[IDX_G5_OD] && latch_q[IDX_G5_OD]) |-> pad_oe_b_o[IDX_G5_OD];
   endproperty
   a_od5: assert property (p_od5)
      else $error("Port-5 open drain not released");

   property p_pullup_off;
      @(posedge clock_i) disable iff (!rst_b_i)
         (pullup_en_o & (~dir_q | analog)) == '0;
   endproperty
   a_pullup_off: assert property (p_pullup_off)
      else $error("Pull-up on in output or analog mode");

   property p_pullup_g3;
      @(posedge clock_i) disable iff (!rst_b_i)
         (pu_q[4] && dir_q[4]) |-> pullup_en_o[4];
   endproperty
   a_pullup_g3: assert property (p_pullup_g3)
      else $error("Port-3 pull-up not applied");

   property p_conv_pick;
      @(posedge clock_i) disable iff (!rst_b_i)
         conv_pick_o[1] |-> (converter_channel_select_i == 5'h01 && analog[1] && dir_q[1]);
   endproperty
   a_conv_pick: assert property (p_conv_pick)
      else $error("Pin converted without selection");

   property p_analog_reads_zero;
      @(posedge clock_i) disable iff (!rst_b_i)
         (rd_sel_i.kind == DPGC_K_DATA && rd_sel_i.grp == DPGC_G2 && analog[0] && dir_q[0])
         |=> (rd_data_o[0] == 1'b0 && rd_data_o[7:4] == 4'h0);
   endproperty
   a_analog_reads_zero: assert property (p_analog_reads_zero)
      else $error("Analog pin did not read zero");

   property p_unmounted_dir;
      @(posedge clock_i) disable iff (!rst_b_i)
         (rd_sel_i.kind == DPGC_K_DIR && rd_sel_i.grp == DPGC_G3) |=> rd_data_o[7:2] == 6'h3f;
   endproperty
   a_unmounted_dir: assert property (p_unmounted_dir)
      else $error("Unmounted direction bits not one");

   property p_pullup_g4;
      @(posedge clock_i) disable iff (!rst_b_i)
         (pu_q[6] && dir_q[6]) |-> pullup_en_o[6];
   endproperty
   a_pullup_g4: assert property (p_pullup_g4)
      else $error("Port-4 pull-up not applied");

   property p_pullup_g7;
      @(posedge clock_i) disable iff (!rst_b_i)
         (pu_q[12] && dir_q[12]) |-> pullup_en_o[12];
   endproperty
   a_pullup_g7: assert property (p_pullup_g7)
      else $error("Port-7 pull-up not applied");

   property p_pullup_g12;
      @(posedge clock_i) disable iff (!rst_b_i)
         (pu_q[IDX_G12_ANA] && dir_q[IDX_G12_ANA] && !group12_analog_digital_select_q) |-> pullup_en_o[IDX_G12_ANA];
   endproperty
   a_pullup_g12: assert property (p_pullup_g12)
      else $error("Port-12 pull-up not applied");

   property p_group12_analog_digital_select_write;
      @(posedge clock_i) disable iff (!rst_b_i)
         (wr_en_i && wr_i.kind == DPGC_K_PMC && wr_i.grp == DPGC_G12) |=>
         (group12_analog_digital_select_q == $past(wr_i.data[0]) && analog[IDX_G12_ANA] == group12_analog_digital_select_q);
   endproperty
   a_group12_analog_digital_select_write: assert property (p_group12_analog_digital_select_write)
      else $error("Port-12 mode select not taken");

   property p_g2_analog_count;
      @(posedge clock_i) disable iff (!rst_b_i)
         analog[3:0] == 4'((5'h01 << conv_cfg_q) - 5'h01);
   endproperty
   a_g2_analog_count: assert property (p_g2_analog_count)
      else $error("Port-2 analog pins not allocated from the lowest");

   property p_drive_low;
      @(posedge clock_i) disable iff (!rst_b_i)
         (!dir_q[0] && !analog[0]) |-> (!pad_oe_b_o[0] && pad_o[0] == latch_q[0]);
   endproperty
   a_drive_low: assert property (p_drive_low)
      else $error("Output-mode pin not driven");

   property p_rd_latch;
      @(posedge clock_i) disable iff (!rst_b_i)
         (rd_sel_i.kind == DPGC_K_DATA && rd_sel_i.grp == DPGC_G3 && !dir_q[4])
         |=> rd_data_o[0] == $past(latch_q[4]);
   endproperty
   a_rd_latch: assert property (p_rd_latch)
      else $error("Output-mode pin did not read its latch");

   c_conv: cover property (@(posedge clock_i) disable iff (!rst_b_i) conv_pick_o[0]);
   c_drive: cover property (@(posedge clock_i) disable iff (!rst_b_i) !pad_oe_b_o[0]);
   c_prohib: cover property (@(posedge clock_i) disable iff (!rst_b_i) prohibited_o);
   c_pullup: cover property (@(posedge clock_i) disable iff (!rst_b_i) pullup_en_o[4]);
   c_od5_out: cover property (@(posedge clock_i) disable iff (!rst_b_i) od5_q && !dir_q[7]);

endmodule : dpgc_port_group

// ===== verification/digital_port_group_ctrl_tb_top.sv
// Purpose: Self-checking bench for the digital port group block
// Assumes: Assertions and covers live in the design files
// Notes:   Driver queues notes, monitor compares them at the falling edge
`timescale 1ns/10ps
module digital_port_group_ctrl_tb_top
   import dpgc_pkg::*;
;
   typedef struct {
      int              due;
      int              what;
      logic [NPIN-1:0] exp;
   } dpgc_note_s;

   logic                  clock_i = 1'b0;
   logic                  rst_b_i = 1'b0;
   logic                  wr_en_i = 1'b0;
   dpgc_wr_s              wr_i    = '0;
   dpgc_rd_s              rd_sel_i = '0;
   logic [4:0]            chan    = 5'h00;
   logic [NPIN-1:0]       pad_i   = '0;
   logic [7:0]            rd_data_o;
   logic [N_CONV_PIN-1:0] conv_pick_o;
   logic [NPIN-1:0]       analog_mode_o, pad_o, pad_oe_b_o, pullup_en_o;
   logic                  prohibited_o;
   dpgc_note_s            notes [$];
   dpgc_note_s            n;
   int                    cyc = 0;
   int                    tcnt = 0;
   int                    err_total = 0;
   int                    checks_done = 0;
   logic [15:0]           rnd = 16'h6e1f;
   logic [7:0]            bv [9];
   logic [NPIN-1:0]       lat, od;

   dpgc_port_group dpgc_port_group_inst (
      .clock_i                    (clock_i),
      .rst_b_i                    (rst_b_i),
      .wr_en_i                    (wr_en_i),
      .wr_i                       (wr_i),
      .rd_sel_i                   (rd_sel_i),
      .rd_data_o                  (rd_data_o),
      .converter_channel_select_i (chan),
      .conv_pick_o                (conv_pick_o),
      .analog_mode_o              (analog_mode_o),
      .prohibited_o               (prohibited_o),
      .pad_i                      (pad_i),
      .pad_o                      (pad_o),
      .pad_oe_b_o                 (pad_oe_b_o),
      .pullup_en_o                (pullup_en_o)
   );

   always #12.5 clock_i = ~clock_i;

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr

   // Spread one group byte onto the flat pin vector
   function automatic logic [NPIN-1:0] gv(input dpgc_grp_e g, input logic [7:0] d);
      logic [NPIN-1:0] v;
      v = '0;
      for (int i = 0; i < NPIN; i++) if (PIN_GRP[i] == g) v[i] = d[PIN_BIT[i]];
      return v;
   endfunction : gv

   task automatic stop_test();
      if (err_total == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : stop_test

   task automatic chk(input string nm, input logic [NPIN-1:0] seen, input logic [NPIN-1:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic note(input int what, input logic [NPIN-1:0] exp);
      notes.push_back('{cyc + 2, what, exp});
   endtask : note

   task automatic wr(input dpgc_kind_e k, input dpgc_grp_e g, input logic [7:0] d);
      @(posedge clock_i);
      wr_en_i <= 1'b1;
      wr_i    <= '{k, g, d};
   endtask : wr

   task automatic rd(input dpgc_kind_e k, input dpgc_grp_e g, input logic [7:0] exp);
      @(posedge clock_i);
      wr_en_i  <= 1'b0;
      rd_sel_i <= '{k, g};
      note(0, {10'h000, exp});
   endtask : rd

   always @(negedge clock_i) begin
      cyc++;
      while (notes.size() > 0 && notes[0].due <= cyc) begin
         n = notes.pop_front();
         case (n.what)
            0: chk("rd_data", {10'h000, rd_data_o}, n.exp);
            1: chk("pad_oe_b", pad_oe_b_o, n.exp);
            2: chk("pullup_en", pullup_en_o, n.exp);
            3: chk("analog_mode", analog_mode_o, n.exp);
            4: chk("conv_pick", {14'h0000, conv_pick_o}, n.exp);
            5: chk("prohibited", {17'h00000, prohibited_o}, n.exp);
            default: chk("pad_o", pad_o & HAS_OUT_MASK, n.exp);
         endcase
      end
   end

   always @(posedge clock_i) begin
      tcnt++;
      if (tcnt == 3000) begin
         err_total++;
         stop_test();
      end
   end

   initial begin
      repeat (12) @(posedge clock_i);
      rst_b_i <= 1'b1;
      rd(DPGC_K_DATA, DPGC_G2, 8'h00);
      note(1, 18'h3ffff);
      note(2, 18'h00000);
      note(3, 18'h2200f);
      for (int k = 0; k < 9; k++) rd(DPGC_K_DIR, dpgc_grp_e'(k), 8'hff);
      for (int k = 0; k < 9; k++) wr(DPGC_K_PULLUP, dpgc_grp_e'(k), 8'hff);
      note(2, 18'h011f0);
      wr(DPGC_K_PMC, DPGC_G12, 8'h00);
      wr(DPGC_K_PMC, DPGC_G14, 8'h00);
      note(3, 18'h0000f);
      note(2, 18'h231f0);
      for (int c = 0; c <= 4; c++) begin
         rnd = lfsr(rnd);
         wr(DPGC_K_CONV, DPGC_G2, c[7:0]);
         chan <= {2'h0, rnd[2:0]};
         note(3, {14'h0000, 4'((1 << c) - 1)});
         note(4, (rnd[2:0] < c) ? 18'h1 << rnd[2:0] : 18'h0);
         @(posedge clock_i);
      end
      wr(DPGC_K_CONV, DPGC_G2, 8'h07);
      note(3, 18'h0000f);
      wr(DPGC_K_DIR, DPGC_G2, 8'h00);
      note(5, 18'h00001);
      note(1, 18'h3ffff);
      wr(DPGC_K_CONV, DPGC_G2, 8'h00);
      note(5, 18'h00000);
      note(1, 18'h3fff0);
      wr(DPGC_K_DIR, DPGC_G2, 8'h05);
      note(1, 18'h3fff5);
      wr(DPGC_K_OD, DPGC_G5, 8'h01);
      lat = '0;
      for (int k = 0; k < 9; k++) begin
         rnd = lfsr(rnd);
         bv[k] = rnd[7:0];
         lat |= gv(dpgc_grp_e'(k), bv[k]);
         wr(DPGC_K_DATA, dpgc_grp_e'(k), bv[k]);
      end
      for (int k = 0; k < 9; k++) wr(DPGC_K_DIR, dpgc_grp_e'(k), 8'h00);
      od = FORCE_OD_MASK | 18'h00080;
      note(1, ~HAS_OUT_MASK | (od & lat));
      note(6, lat & ~od & HAS_OUT_MASK);
      note(2, 18'h00000);
      rd(DPGC_K_DATA, DPGC_G3, bv[1] & 8'h03);
      rd(DPGC_K_DIR, DPGC_G4, 8'hfe);
      rd(DPGC_K_DIR, DPGC_G13, 8'hff);
      wr(DPGC_K_DIR, DPGC_G3, 8'hff);
      rnd = lfsr(rnd);
      pad_i <= {rnd[15:0], rnd[1:0]};
      repeat (6) @(posedge clock_i);
      rd(DPGC_K_DATA, DPGC_G3, {6'h00, rnd[3:2]});
      rd(DPGC_K_DATA, DPGC_G13, {rnd[14], 7'h00});
      note(2, 18'h00030);
      repeat (4) @(posedge clock_i);
      stop_test();
   end
endmodule : digital_port_group_ctrl_tb_top
